// *** rtl/rbm_reset_boot.sv ***
// reset sequencer, boot mode selection, irq sensing and pull-up control
// Overview of operation
// - each irq input level or falling edge
// - disable bit turns that irq pull-up off
// - low reset input holds device in reset
// - internal reset released after fixed clock count
// - power-on circuit asserts internal reset
// - reset output follows internal chip reset
// - boot strap masked low internally: boot always internal
// - memory mode strap masked low internally: memory mode always off
// - clock from crystal, resonator or external
`timescale 1ns/10ps
`default_nettype none
module rbm_reset_boot
  import rbm_pkg::*;
#(
  parameter int NUM_IRQ = RBM_NUM_IRQ,
  parameter int RELEASE_CYCLES = RBM_RELEASE_CYCLES,
  parameter int POR_CYCLES = RBM_POR_CYCLES
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // external reset, active low
  input wire logic power_on, // low until supply is valid
  input wire logic flash_unsecured, // flash security state
  input wire logic external_boot_strap, // boot strap pin level
  input wire logic ext_mem_mode_strap, // memory mode strap pin level
  input wire logic [1:0] clock_src_sel, // clock source choice
  input wire logic [NUM_IRQ-1:0] ext_irq_a, // external irq pins
  input wire logic [NUM_IRQ-1:0] irq_edge_mode, // 1 = falling edge, 0 = level
  input wire logic [NUM_IRQ-1:0] irq_ack, // clears a latched edge
  input wire logic pud_we, // boot software write strobe
  input wire logic [RBM_PUD_W-1:0] pud_wdata, // pull-up disable write data
  output logic [RBM_PUD_W-1:0] pullup_disable_reg, // pull-up disable state
  output logic [NUM_IRQ-1:0] irq_pullup_en, // pull-up enables on irq pins
  output logic boot_strap_pullup_off, // boot strap pull-up off
  output logic emi_strap_pullup_off, // memory strap pull-up off
  output logic [NUM_IRQ-1:0] irq_req, // interrupt requests to core
  output logic chip_reset_n, // internal chip reset, active low
  output logic reset_out, // reset pin, high in reset
  output logic boot_mode, // 1 = external boot
  output logic ext_mem_mode, // memory mode latched at reset
  output logic [1:0] clock_synth // selected clock source
);
  // ****************************************
  // reset sequencer
  // ****************************************
  rbm_state_e state; // sequencer state
  rbm_state_e next_state; // next state
  logic [RBM_CNT_W-1:0] cnt; // cycle counter
  logic [RBM_CNT_W-1:0] next_cnt; // next counter value
  wire por_done = (cnt >= RBM_CNT_W'(POR_CYCLES - 1)); // stretch elapsed
  wire rel_done = (cnt >= RBM_CNT_W'(RELEASE_CYCLES - 1)); // release count elapsed

  // next state decode
  always_comb begin
    next_state = state;
    next_cnt = cnt + 8'h01;
    unique case (state)
      RBM_ST_POR: begin
        if (por_done) begin
          next_state = RBM_ST_HOLD;
          next_cnt = RBM_CNT_RESET;
        end
      end
      RBM_ST_HOLD: begin
        if (rel_done) begin
          next_state = RBM_ST_RUN;
          next_cnt = RBM_CNT_RESET;
        end
      end
      RBM_ST_RUN: begin
        next_cnt = RBM_CNT_RESET; // idle
      end
      default: begin
        next_state = RBM_ST_POR;
        next_cnt = RBM_CNT_RESET;
      end
    endcase
  end

  // state register; power loss restarts the stretch
  always_ff @(posedge clock) begin
    if (!power_on) begin
      state <= RBM_ST_POR;
      cnt <= RBM_CNT_RESET;
    end else if (!rst_n) begin
      state <= (state == RBM_ST_POR) ? RBM_ST_POR : RBM_ST_HOLD;
      cnt <= (state == RBM_ST_POR) ? next_cnt : RBM_CNT_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ****************************************
  // reset outputs
  // ****************************************
  wire in_reset = (state != RBM_ST_RUN); // internal chip reset active
  wire rel_edge = (state == RBM_ST_HOLD) && rel_done && rst_n && power_on; // last reset cycle
  assign chip_reset_n = !in_reset;
  assign reset_out = in_reset;

  // ****************************************
  // boot mode latch at reset release
  // ****************************************
  wire boot_strap_int = 1'b0 & external_boot_strap;
  wire emi_strap_int = 1'b0 & ext_mem_mode_strap;
  wire boot_sel = (boot_strap_int && flash_unsecured) ? RBM_BOOT_EXTERNAL
                                                      : RBM_BOOT_INTERNAL;

  // straps captured in the last reset cycle
  always_ff @(posedge clock) begin
    if (!power_on) begin
      boot_mode <= RBM_BOOT_INTERNAL;
      ext_mem_mode <= 1'b0;
      clock_synth <= RBM_CLK_RESONATOR;
    end else if (rel_edge) begin
      boot_mode <= boot_sel;
      ext_mem_mode <= boot_sel && emi_strap_int;
      clock_synth <= (clock_src_sel == 2'h3) ? RBM_CLK_RESONATOR : clock_src_sel;
    end
  end

  // ****************************************
  // pull-up disable register
  // ****************************************
  // written by boot software, cleared by chip reset
  always_ff @(posedge clock) begin
    if (in_reset) begin
      pullup_disable_reg <= RBM_PUD_RESET;
    end else if (pud_we) begin
      pullup_disable_reg <= pud_wdata;
    end
  end
  assign boot_strap_pullup_off = pullup_disable_reg[RBM_PUD_BOOT];
  assign emi_strap_pullup_off = pullup_disable_reg[RBM_PUD_EMI];

  // ****************************************
  // external interrupt sensing
  // ****************************************
  logic [NUM_IRQ-1:0] irq_prev; // previous pin level
  logic [NUM_IRQ-1:0] irq_edge; // latched falling edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      wire fall = irq_prev[gi] && !ext_irq_a[gi]; // falling edge seen
      // edge latch; a new edge beats an acknowledge
      always_ff @(posedge clock) begin
        if (in_reset) begin
          irq_prev[gi] <= 1'b1;
          irq_edge[gi] <= 1'b0;
        end else begin
          irq_prev[gi] <= ext_irq_a[gi];
          irq_edge[gi] <= fall || (irq_edge[gi] && !irq_ack[gi]);
        end
      end
      assign irq_req[gi] = irq_edge_mode[gi] ? irq_edge[gi] : !ext_irq_a[gi];
      assign irq_pullup_en[gi] = !pullup_disable_reg[gi];
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  property p_hold_in_reset;
    @(posedge clock) disable iff (!power_on) !rst_n |=> reset_out;
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset) else $error("reset not held");

  // counts held-reset cycles apart from the sequencer counter
  logic [RBM_CNT_W-1:0] chk_rel_cnt; // release cycles seen so far
  always_ff @(posedge clock) begin
    if (state == RBM_ST_HOLD && rst_n && power_on) begin
      chk_rel_cnt <= chk_rel_cnt + 8'h01; // still counting out
    end else begin
      chk_rel_cnt <= RBM_CNT_RESET; // any other state restarts it
    end
  end
  sequence s_released;
    $rose(chip_reset_n);
  endsequence
  // release must come after exactly the fixed count, for counts from 1 to 256 (both counters are 8 bits)
  property p_release_count;
    @(posedge clock) disable iff (!power_on)
      s_released |-> chk_rel_cnt == RBM_CNT_W'(RELEASE_CYCLES);
  endproperty
  a_release_count: assert property (p_release_count) else $error("reset released early");

  property p_por;
    @(posedge clock) !power_on |=> reset_out && state == RBM_ST_POR;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset missing");

  property p_reset_out;
    @(posedge clock) reset_out == !chip_reset_n;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset pin mismatch");

  property p_internal_boot;
    @(posedge clock) disable iff (!power_on) !reset_out |-> boot_mode == RBM_BOOT_INTERNAL;
  endproperty
  a_internal_boot: assert property (p_internal_boot) else $error("boot not internal");

  property p_ext_mem_mode_strap;
    @(posedge clock) disable iff (!power_on) ext_mem_mode |-> boot_mode;
  endproperty
  a_ext_mem_mode_strap: assert property (p_ext_mem_mode_strap) else $error("memory mode without boot");

  property p_pullup;
    @(posedge clock) disable iff (!power_on)
      (!in_reset && pud_we && pud_wdata[0]) |=> !irq_pullup_en[0];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not disabled");

  property p_edge_irq;
    @(posedge clock) disable iff (in_reset)
      (irq_edge_mode[0] && $fell(ext_irq_a[0])) |=> irq_req[0];
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge irq lost");

  property p_clk_src;
    @(posedge clock) disable iff (!power_on) clock_synth != 2'h3;
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("bad clock source");
endmodule
`default_nettype wire

// *** rtl/rbm_pkg.sv ***
// constants shared by the reset and boot-mode block
package rbm_pkg;
  // ****************************************
  // reset sequencing
  // ****************************************
  localparam int RBM_RELEASE_CYCLES = 32; // internal clocks from release to deassert
  localparam int RBM_POR_CYCLES = 16; // power-on reset stretch
  localparam int RBM_CNT_W = 8; // width of the reset counters
  localparam logic [7:0] RBM_CNT_RESET = 8'h00; // counter value in reset
  // ****************************************
  // boot and clock source encodings
  // ****************************************
  localparam logic RBM_BOOT_INTERNAL = 1'b0; // mode 0
  localparam logic RBM_BOOT_EXTERNAL = 1'b1; // mode 1
  localparam logic [1:0] RBM_CLK_CRYSTAL = 2'h0; // crystal
  localparam logic [1:0] RBM_CLK_RESONATOR = 2'h1; // ceramic resonator, default
  localparam logic [1:0] RBM_CLK_EXTERNAL = 2'h2; // external clock signal
  // ****************************************
  // pull-up disable bit positions
  // ****************************************
  localparam int RBM_NUM_IRQ = 2; // interrupt request inputs
  localparam int RBM_PUD_BOOT = 2; // boot strap pull-up off bit
  localparam int RBM_PUD_EMI = 3; // memory mode strap pull-up off bit
  localparam int RBM_PUD_W = 4; // pull-up disable width
  localparam logic [3:0] RBM_PUD_RESET = 4'h0; // all pull-ups on after reset
  // reset sequencer states
  typedef enum logic [2:0] {
    RBM_ST_POR = 3'h1, // power-on stretch
    RBM_ST_HOLD = 3'h2, // counting after release
    RBM_ST_RUN = 3'h4 // internal reset released
  } rbm_state_e;
endpackage

// *** bench/rbm_board_model.sv ***
// board side model: reset source, debug port and strap pins
`timescale 1ns/10ps
`default_nettype none
module rbm_board_model (
  input wire logic hw_reset_req, // full hardware reset request
  input wire logic dbg_reset_req, // debug device-only reset request
  output logic rst_n, // device reset, active low
  output logic trst_n, // test reset, active low
  output logic external_boot_strap, // boot strap pin
  output logic ext_mem_mode_strap // memory mode strap pin
);
  // full reset pulls both lines, debug reset only the device line
  assign rst_n = !(hw_reset_req || dbg_reset_req);
  assign trst_n = !hw_reset_req;
  // straps held high so a forced-low package shows
  assign external_boot_strap = 1'b1;
  assign ext_mem_mode_strap = 1'b1;
endmodule
`default_nettype wire

// *** bench/tb_rbm_reset_boot.sv ***
// testbench for the reset and boot-mode block
`timescale 1ns/10ps
`default_nettype none
module tb_rbm_reset_boot;
  import rbm_pkg::*;
  localparam int REL = 4; // shortened release count
  localparam int POR = 4; // shortened power-on stretch
  logic clock = 1'b0, power_on = 1'b0, flash_unsecured = 1'b1, pud_we = 1'b0;
  logic hw_req = 1'b1, dbg_req = 1'b0, rst_n, trst_n, xb, xm;
  logic [1:0] clock_src_sel = 2'h1, ext_irq_a = 2'h3, irq_edge_mode = 2'h0, irq_ack = 2'h0;
  logic [3:0] pud_wdata = 4'h0, pud_reg;
  logic [1:0] pu_en, irq_req, clk_syn;
  logic bs_off, emi_off, chip_reset_n, reset_out, boot_mode, ext_mem_mode;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  always #50 clock = ~clock;
  rbm_board_model brd (.hw_reset_req(hw_req), .dbg_reset_req(dbg_req), .rst_n(rst_n),
    .trst_n(trst_n), .external_boot_strap(xb), .ext_mem_mode_strap(xm));
  rbm_reset_boot #(.RELEASE_CYCLES(REL), .POR_CYCLES(POR)) uut (.clock(clock), .rst_n(rst_n),
    .power_on(power_on), .flash_unsecured(flash_unsecured), .external_boot_strap(xb),
    .ext_mem_mode_strap(xm), .clock_src_sel(clock_src_sel), .ext_irq_a(ext_irq_a),
    .irq_edge_mode(irq_edge_mode), .irq_ack(irq_ack), .pud_we(pud_we), .pud_wdata(pud_wdata),
    .pullup_disable_reg(pud_reg), .irq_pullup_en(pu_en), .boot_strap_pullup_off(bs_off),
    .emi_strap_pullup_off(emi_off), .irq_req(irq_req), .chip_reset_n(chip_reset_n),
    .reset_out(reset_out), .boot_mode(boot_mode), .ext_mem_mode(ext_mem_mode),
    .clock_synth(clk_syn));
  // value compare
  task check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // closing report
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  // wait for reset release, judge the count
  task wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (reset_out !== 1'b0 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    check("release_in_window", 8'h1, {7'h0, n >= lo && n <= hi});
    check("chip_reset_n", 8'h1, {7'h0, chip_reset_n});
  endtask
  task write_pud(input logic [3:0] d);
    @(posedge clock) pud_we <= 1'b1;
    pud_wdata <= d;
    @(posedge clock) pud_we <= 1'b0;
    #1;
  endtask
  // power-on stretch then release
  task t_por;
    @(posedge clock) #1 check("por_held", 8'h1, {7'h0, reset_out});
    @(posedge clock) power_on <= 1'b1;
    hw_req <= 1'b0;
    wait_run(POR + REL - 1, POR + REL + 3);
    $display("test por done");
  endtask
  // pull-up disable bits, then a reset that clears them
  task t_pud;
    write_pud(4'h5);
    check("pud_reg", 8'h5, {4'h0, pud_reg});
    check("irq_pu", 8'h2, {6'h0, pu_en});
    write_pud(4'ha);
    check("pu_off", 8'h2, {6'h0, emi_off, bs_off});
    check("irq_pu2", 8'h1, {6'h0, pu_en});
    @(posedge clock) dbg_req <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("in_reset", 8'h0, {7'h0, chip_reset_n});
    check("reset_out", 8'h1, {7'h0, reset_out});
    check("trst_dbg", 8'h1, {7'h0, trst_n});
    write_pud(4'hf);
    @(posedge clock) dbg_req <= 1'b0;
    wait_run(REL - 1, REL + 2);
    check("pud_cleared", 8'h0, {4'h0, pud_reg});
    $display("test pull-up done");
  endtask
  // level and falling-edge requests
  task t_irq;
    @(posedge clock) ext_irq_a <= 2'h2;
    #1 check("level_req", 8'h1, {6'h0, irq_req});
    @(posedge clock) ext_irq_a <= 2'h3;
    irq_edge_mode <= 2'h3;
    irq_ack <= 2'h3; // drop the edge latched while in level mode
    @(posedge clock) ext_irq_a <= 2'h0;
    irq_ack <= 2'h0;
    @(posedge clock) ext_irq_a <= 2'h3;
    @(posedge clock) #1 check("edge_req", 8'h3, {6'h0, irq_req});
    @(posedge clock) irq_ack <= 2'h3;
    @(posedge clock) irq_ack <= 2'h0;
    #1 check("edge_ack", 8'h0, {6'h0, irq_req});
    $display("test irq done");
  endtask
  // boot mode and clock source over resets
  task t_boot;
    for (int s = 0; s < 4; s++) begin
      @(posedge clock) clock_src_sel <= s[1:0];
      hw_req <= 1'b1;
      repeat (3) @(posedge clock);
      check("trst_hw", 8'h0, {7'h0, trst_n});
      hw_req <= 1'b0;
      wait_run(REL - 1, REL + 2);
      check("boot_mode", {7'h0, RBM_BOOT_INTERNAL}, {7'h0, boot_mode});
      check("mem_mode", 8'h0, {7'h0, ext_mem_mode});
      check("clk_src", (s == 3) ? {6'h0, RBM_CLK_RESONATOR} : {6'h0, s[1:0]}, {6'h0, clk_syn});
    end
    $display("test boot done");
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    t_por;
    t_pud;
    t_irq;
    t_boot;
    finish_test;
  end
endmodule
`default_nettype wire
